// *** rtl/usb_clk_share_pkg.sv ***
// Shared constants and carrier types for the USB host clock and port-share block
package usb_clk_share_pkg;

    // Documented figures: clocks in MHz, then divide settings, bit rate and counts
    localparam int HS_PLL_MHZ        = 480;
    localparam int UTMI_CLK_MHZ      = 30;
    localparam int FS_48_MHZ         = 48;
    localparam int FS_12_MHZ         = 12;
    localparam int FS_12_DIVIDE      = 4;
    localparam int HS_FS_DIV_SETTING = 9;
    localparam int FS_BIT_RATE_MBPS  = 12;
    localparam int MAX_USB_DEVICES   = 127;
    localparam int TRANSCEIVER_COUNT = 2;
    localparam int SHARED_XCVR_INDEX = 1;

    // Field widths, reset values and the last quarter count of the divide by four
    localparam int           DIV_W           = 4;
    localparam logic [3:0]   DIV_RESET       = 4'h0;
    localparam int           COUNT_W         = 4;
    localparam logic [3:0]   STARTUP_RESET   = 4'h0;
    localparam logic [1:0]   DIV12_LAST      = 2'h3;

    // Line signal group of one port
    typedef struct packed {
        logic fs_plus;
        logic fs_minus;
        logic hs_plus;
        logic hs_minus;
    } usb_lines_s;

    // Clock configuration from software
    typedef struct packed {
        logic             periph_clk_enable;
        logic             hs_pll_enable;
        logic             transceiver_bias_enable;
        logic             fs_clock_source_select;
        logic [DIV_W-1:0] fs_clock_divider;
        logic             fs_clock_gate;
    } clk_cfg_s;

    typedef enum logic [1:0] {
        OWNER_HOST,
        OWNER_DEVICE
    } owner_e;

endpackage : usb_clk_share_pkg

// *** rtl/fs_clock_divider_gen.sv ***
// Programmable divider producing the 48 MHz strobe and its divide-by-four 12 MHz strobe
`timescale 1ns/1ps
`default_nettype none
module fs_clock_divider_gen
#(
    parameter int DIV_W = 4
)
(
    // Clock and reset
    input  wire logic             src_clk_in,
    input  wire logic             sys_rst_in,
    // Control
    input  wire logic             run_in,
    input  wire logic [DIV_W-1:0] divide_in,
    // Strobes
    output logic                  fs_48_out,
    output logic                  fs_12_out
);
    import usb_clk_share_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic [1:0]       quarter;
        logic             tick48;
        logic             tick12;
    } div_state_s;

    div_state_s state;
    div_state_s next_state;

    always_comb
    begin
        next_state        = state;
        next_state.tick48 = 1'b0;
        next_state.tick12 = 1'b0;
        if (!run_in)
        begin
            next_state.count   = '0;
            next_state.quarter = 2'h0;
        end
        else if (state.count >= divide_in)
        begin
            // Setting N divides by N+1
            next_state.count   = '0;
            next_state.tick48  = 1'b1;
            next_state.quarter = state.quarter + 2'h1;
            next_state.tick12  = (state.quarter == DIV12_LAST);
        end
        else
        begin
            next_state.count = state.count + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge src_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign fs_48_out = state.tick48;
    assign fs_12_out = state.tick12;

endmodule : fs_clock_divider_gen
`default_nettype wire

// *** rtl/usb_host_clock_and_port_share.sv ***
// USB host clock selection, full-speed clock generation and port-A transceiver share
// Contract
// RULE_01: Port-A transceiver goes to the device controller whenever its enable bit is set, else host A.
// RULE_02: With host A owning the transceiver, host A fs/hs lines are routed instead of device lines.
// RULE_03: The high-speed transceivers are fed the 480 MHz clock from the high-speed PLL.
// RULE_04: With the high-speed PLL stopped, hs is unavailable but fs still works from the main PLL.
// RULE_05: The high-speed transceiver returns a 30 MHz clock to the host controller.
// RULE_06: Full-speed 48 and 12 MHz clocks come from a PLL held within 0.25 percent by the divider.
// RULE_07: The 12 MHz full-speed clock is the 48 MHz clock divided by four.
// RULE_08: Software enables peripheral clock, count, PLL, waits lock, bias, select, divider, gate.
// RULE_09: With the high-speed PLL selected, software sets the divider field to 9 (divide by ten).
// RULE_10: For fs-only use, software clears select, programs divider for the main PLL, enables gate.
// RULE_11: Source select picks the high-speed PLL when set and the main PLL when clear.
// RULE_12: The host has one interrupt line; software sets up the interrupt controller first.
// RULE_13: Root hub offers 12 Mbit/s half-duplex fs ports for up to 127 devices in a tiered star.
// RULE_14: Transceiver line pins are driven only by the host controller, never by general I/O; port A takes device lines when the device owns it.
// RULE_15: Two transceivers exist and host port A uses the second, shared one.
// RULE_16: Software changes port-A ownership only while both sides are idle on that transceiver.
`timescale 1ns/1ps
`default_nettype none
module usb_host_clock_and_port_share
    import usb_clk_share_pkg::*;
(
    // System clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          sys_rst_in,
    // Clock sources
    input  wire logic                          hs_pll_clock_in,
    input  wire logic                          main_pll_clock_in,
    input  wire logic                          hs_pll_locked_in,
    input  wire logic                          utmi_clock_in,
    // Software configuration
    input  wire usb_clk_share_pkg::clk_cfg_s   clk_cfg_in,
    input  wire logic [usb_clk_share_pkg::COUNT_W-1:0] hs_pll_startup_count_in,
    input  wire logic                          device_port_owner_enable_in,
    // Line signals from the controllers
    input  wire usb_clk_share_pkg::usb_lines_s host_a_lines_in,
    input  wire usb_clk_share_pkg::usb_lines_s host_b_lines_in,
    input  wire usb_clk_share_pkg::usb_lines_s dev_lines_in,
    // Transceiver feeds
    output var usb_clk_share_pkg::usb_lines_s  xcvr_a_lines_out,
    output var usb_clk_share_pkg::usb_lines_s  xcvr_b_lines_out,
    output logic                               xcvr_hs_clock_out,
    output logic                               xcvr_bias_out,
    output logic                               host_utmi_clock_out,
    // Full-speed clocks to the host controller
    output logic                               fs_source_clock_out,
    output logic                               fs_clock_48_out,
    output logic                               fs_clock_12_out,
    // Status
    output logic                               periph_clock_out,
    output logic                               hs_available_out,
    output logic                               fs_available_out,
    output var usb_clk_share_pkg::owner_e      port_a_owner_out,
    output logic [usb_clk_share_pkg::COUNT_W-1:0] hs_pll_startup_count_out
);
    import usb_clk_share_pkg::*;

    typedef struct packed {
        owner_e               owner;
        usb_lines_s           port_a;
        usb_lines_s           port_b;
        logic                 hs_ok;
        logic                 fs_ok;
        logic                 bias;
        logic                 periph;
        logic [COUNT_W-1:0]   startup;
    } share_state_s;

    share_state_s state;
    share_state_s next_state;
    logic         fs_src_clk;
    logic         fs_run;

    // Clock muxing is left as plain selection; a glitch-free switch belongs
    // to the clock tree cell, and software only switches with the gate off
    assign fs_src_clk = clk_cfg_in.fs_clock_source_select
                      ? hs_pll_clock_in : main_pll_clock_in; // see RULE_11
    assign fs_run     = clk_cfg_in.fs_clock_gate & clk_cfg_in.periph_clk_enable;

    always_comb
    begin
        next_state        = state;
        next_state.owner  = device_port_owner_enable_in
                          ? OWNER_DEVICE : OWNER_HOST; // see RULE_01
        // Shared transceiver is the second one; host B keeps the first
        next_state.port_b = host_b_lines_in; // see RULE_15
        case (next_state.owner)
            OWNER_DEVICE: next_state.port_a = dev_lines_in;
            OWNER_HOST:   next_state.port_a = host_a_lines_in; // see RULE_02
            default:      next_state.port_a = host_a_lines_in;
        endcase
        // High speed needs the running, locked PLL
        next_state.hs_ok  = clk_cfg_in.hs_pll_enable & hs_pll_locked_in
                          & clk_cfg_in.transceiver_bias_enable; // see RULE_04
        // Full speed survives PLL stop when the main PLL is the source
        next_state.fs_ok  = fs_run & (~clk_cfg_in.fs_clock_source_select
                          | (clk_cfg_in.hs_pll_enable & hs_pll_locked_in)); // see RULE_04
        next_state.bias   = clk_cfg_in.transceiver_bias_enable;
        next_state.periph = clk_cfg_in.periph_clk_enable;
        next_state.startup = hs_pll_startup_count_in;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state       <= '0;
            state.owner <= OWNER_HOST;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Line pins come only from controllers, never from general I/O
    assign xcvr_a_lines_out = state.port_a; // see RULE_14
    assign xcvr_b_lines_out = state.port_b; // see RULE_14
    assign port_a_owner_out = state.owner;

    // 480 MHz feed gated by PLL enable so a stopped PLL leaves no clock
    assign xcvr_hs_clock_out   = hs_pll_clock_in & clk_cfg_in.hs_pll_enable; // see RULE_03
    assign xcvr_bias_out       = state.bias;
    assign host_utmi_clock_out = utmi_clock_in; // see RULE_05
    assign fs_source_clock_out = fs_src_clk;

    // Divider accuracy is the software's choice; 9 with 480 MHz gives 48 MHz
    fs_clock_divider_gen #(
        .DIV_W      (DIV_W)
    ) u_fs_div (
        .src_clk_in (fs_src_clk),
        .sys_rst_in (sys_rst_in),
        .run_in     (fs_run),
        .divide_in  (clk_cfg_in.fs_clock_divider),
        .fs_48_out  (fs_clock_48_out),  // see RULE_06
        .fs_12_out  (fs_clock_12_out)   // see RULE_07 RULE_13
    );

    assign periph_clock_out         = state.periph;
    assign hs_available_out         = state.hs_ok;
    assign fs_available_out         = state.fs_ok;
    assign hs_pll_startup_count_out = state.startup;

endmodule : usb_host_clock_and_port_share
`default_nettype wire

// *** tb/usb_clk_share_sva.sv ***
// Port checker for the USB clock and port-share block
`timescale 1ns/1ps
`default_nettype none
module usb_clk_share_sva
    import usb_clk_share_pkg::*;
(
    input wire logic sys_clk_in, sys_rst_in, hs_pll_clock_in, main_pll_clock_in,
    input wire logic hs_pll_locked_in, utmi_clock_in, device_port_owner_enable_in,
    input wire clk_cfg_s clk_cfg_in,
    input wire usb_lines_s host_a_lines_in, dev_lines_in, xcvr_a_lines_out,
    input wire logic xcvr_hs_clock_out, host_utmi_clock_out, fs_source_clock_out,
    input wire logic fs_clock_48_out, fs_clock_12_out, hs_available_out, fs_available_out,
    input wire owner_e port_a_owner_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [1:0] n48;
    // Restarts with the divider, which idles while gated off
    always_ff @(posedge fs_source_clock_out or posedge sys_rst_in)
        if (sys_rst_in || !(clk_cfg_in.fs_clock_gate && clk_cfg_in.periph_clk_enable))
            n48 <= 2'h0;
        else if (fs_clock_48_out)
            n48 <= n48 + 2'h1;
    AST_OWNER: assert property (1 |=> port_a_owner_out ==
        ($past(device_port_owner_enable_in) ? OWNER_DEVICE : OWNER_HOST)) else $error("owner");
    AST_ROUTE: assert property (1 |=> xcvr_a_lines_out ==
        ($past(device_port_owner_enable_in) ? $past(dev_lines_in) : $past(host_a_lines_in)))
        else $error("port A lines");
    AST_HSCLK: assert property (xcvr_hs_clock_out ==
        (hs_pll_clock_in && clk_cfg_in.hs_pll_enable)) else $error("hs clock");
    AST_UTMI: assert property (host_utmi_clock_out == utmi_clock_in)
        else $error("utmi clock");
    AST_SRC: assert property (fs_source_clock_out == (clk_cfg_in.fs_clock_source_select ?
        hs_pll_clock_in : main_pll_clock_in)) else $error("fs source");
    AST_HSAV: assert property (1 |=> hs_available_out == $past(clk_cfg_in.hs_pll_enable
        && hs_pll_locked_in && clk_cfg_in.transceiver_bias_enable)) else $error("hs avail");
    AST_FSAV: assert property (!clk_cfg_in.fs_clock_source_select && clk_cfg_in.fs_clock_gate
        && clk_cfg_in.periph_clk_enable |=> fs_available_out) else $error("fs avail");
    AST_FS12: assert property (@(posedge fs_source_clock_out) disable iff (sys_rst_in)
        fs_clock_12_out == (fs_clock_48_out && n48 == 2'h3)) else $error("12 strobe");
    COV_DEV: cover property (port_a_owner_out == OWNER_DEVICE);
    COV_HS: cover property ($rose(hs_available_out));
    COV_12: cover property (@(posedge fs_source_clock_out) fs_clock_12_out);
endmodule : usb_clk_share_sva
bind usb_host_clock_and_port_share usb_clk_share_sva u_usb_clk_share_sva (.*);
`default_nettype wire

// *** tb/usb_clk_partner.sv ***
// Behavioural PLL and transceiver clock sources
`timescale 1ns/1ps
`default_nettype none
module usb_clk_partner
(
    // Controls
    input  wire logic       pll_enable_in,
    input  wire logic       bias_in,
    input  wire logic [3:0] startup_in,
    // Clocks and lock flag
    output logic            hs_clk_out,
    output logic            main_clk_out,
    output logic            utmi_clk_out,
    output logic            locked_out
);
    initial {hs_clk_out, main_clk_out, utmi_clk_out, locked_out} = 4'h0;
    // Stopped clocks park low, never at their last level
    always #1.0417 hs_clk_out = pll_enable_in && !hs_clk_out;
    always #5 main_clk_out = !main_clk_out;
    always #16.667 utmi_clk_out = bias_in && locked_out && !utmi_clk_out;
    always @(pll_enable_in)
    begin
        locked_out = 1'b0;
        if (pll_enable_in)
            repeat (8 * startup_in + 8) @(posedge hs_clk_out);
        locked_out = pll_enable_in;
    end
endmodule : usb_clk_partner
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the USB clock and port-share block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import usb_clk_share_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, own = 1'b0, hs, mn, ut, lk, hck, bias, uo, src, f48, f12;
    logic       per, hav, fav;
    logic [3:0] cnt = 4'h2, co;
    clk_cfg_s   cfg = '0;
    usb_lines_s ha = '0, hb = '0, dv = '0, xa, xb;
    owner_e     ow;
    int         mismatches = 0, total_checks = 0, i;
    logic [12:0] rows [4] = '{13'h0a5a, 13'h1a55, 13'h13cc, 13'h0f0f};
    always #12.5 clk = !clk;
    usb_clk_partner u_usb_clk_partner (.pll_enable_in(cfg.hs_pll_enable), .bias_in(bias),
        .startup_in(co), .hs_clk_out(hs), .main_clk_out(mn), .utmi_clk_out(ut), .locked_out(lk));
    usb_host_clock_and_port_share u_usb_host_clock_and_port_share (.sys_clk_in(clk),
        .sys_rst_in(rst), .hs_pll_clock_in(hs), .main_pll_clock_in(mn), .hs_pll_locked_in(lk),
        .utmi_clock_in(ut), .clk_cfg_in(cfg), .hs_pll_startup_count_in(cnt),
        .device_port_owner_enable_in(own), .host_a_lines_in(ha), .host_b_lines_in(hb),
        .dev_lines_in(dv), .xcvr_a_lines_out(xa), .xcvr_b_lines_out(xb), .xcvr_hs_clock_out(hck),
        .xcvr_bias_out(bias), .host_utmi_clock_out(uo), .fs_source_clock_out(src),
        .fs_clock_48_out(f48), .fs_clock_12_out(f12), .periph_clock_out(per),
        .hs_available_out(hav), .fs_available_out(fav), .port_a_owner_out(ow),
        .hs_pll_startup_count_out(co));
    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // Counts source edges between strobes; the gap is the divider setting plus one
    task automatic meas(input int gap);
        int n = 0;
        int last = 0;
        int p = 0;
        for (int k = 0; k < 400 && p < 8; k++)
        begin
            @(negedge src);
            n++;
            if (f48 === 1'b1)
            begin
                if (p > 0) chk("fs_48_gap", 4'(gap), 4'(n - last));
                p++;
                last = n;
                chk("fs_12", 4'(p % 4 == 0), 4'(f12));
            end
        end
        chk("fs_48_count", 4'h8, 4'(p));
        // Back onto the bench's falling edge before inputs move again
        @(negedge clk);
    endtask : meas
    initial
    begin
        // No interrupt line here; controller setup order is software's
        repeat (12) @(negedge clk);
        rst = 1'b0;
        foreach (rows[r])
        begin
            {own, ha, dv} = rows[r][12:4];
            hb = ~ha;
            @(negedge clk);
            chk("xcvr_a", rows[r][3:0], xa);
            chk("owner", {3'h0, own}, 4'(ow));
            chk("xcvr_b", ~ha, xb);
        end
        // Full-speed only, from the main PLL
        cfg.periph_clk_enable = 1'b1;
        cfg.fs_clock_divider = 4'h1;
        cfg.fs_clock_gate = 1'b1;
        meas(2);
        chk("fs_avail", 4'h1, 4'(fav));
        cfg.fs_clock_gate = 1'b0;
        cfg.hs_pll_enable = 1'b1;
        for (i = 0; i < 100 && lk !== 1'b1; i++) @(negedge clk);
        if (lk !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
        cfg.transceiver_bias_enable = 1'b1;
        cfg.fs_clock_source_select = 1'b1;
        cfg.fs_clock_divider = 4'h9;
        repeat (2) @(negedge clk);
        cfg.fs_clock_gate = 1'b1;
        meas(10);
        chk("hs_avail", 4'h1, 4'(hav));
        chk("startup", 4'h2, co);
        chk("periph", 4'h1, 4'(per));
        chk("bias", 4'h1, 4'(bias));
        cfg.fs_clock_gate = 1'b0;
        cfg.hs_pll_enable = 1'b0;
        repeat (2) @(negedge clk);
        cfg.fs_clock_source_select = 1'b0;
        cfg.fs_clock_divider = 4'h1;
        repeat (2) @(negedge clk);
        cfg.fs_clock_gate = 1'b1;
        meas(2);
        chk("hs_avail_off", 4'h0, 4'(hav));
        chk("hs_clock_off", 4'h0, 4'(hck));
        rst = 1'b1;
        @(negedge clk);
        chk("owner_rst", 4'h0, 4'(ow));
        chk("xcvr_a_rst", 4'h0, xa);
        // Ownership moves on the first clock after reset is released
        own = 1'b1;
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk("owner_back", 4'h1, 4'(ow));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
